// ---- design/tws_blkmem.v ----
// fifteen-block write buffer storage with registered read data
`timescale 1ns/1ps
`include "tws_defs.vh"
module tws_blkmem
(
  // clock
  input wire clk,
  // write side
  input wire wr_en,
  input wire [`TWS_AW-1:0] wr_addr,
  input wire [`TWS_BLK_W-1:0] wr_data,
  // read side
  input wire [`TWS_AW-1:0] rd_addr,
  output reg [`TWS_BLK_W-1:0] rd_data
);
  reg [`TWS_BLK_W-1:0] mem [0:`TWS_DEPTH-1];

  // ==========================================================
  // storage; no reset so it maps onto plain ram
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

// ---- design/tws_sequencer.v ----
// write command sequencer: decode, buffering, streaming, status
// ==========================================================
`timescale 1ns/1ps
`include "tws_defs.vh"
module tws_sequencer
(
  // clock and reset
  input wire clk,
  input wire reset_n,
  // command block from host
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [47:0] cmd_block,
  // positioning state left by earlier commands
  input wire prev_write_type,
  input wire prev_positions_write,
  input wire beginning_of_media_flag,
  output wire read_start,
  // configuration
  input wire buffered_mode,
  input wire disconnect_allowed,
  input wire qic24_mode,
  input wire set_param_strobe,
  input wire [7:0] set_param_min_blocks,
  input wire set_param_extended,
  input wire mode_select_strobe,
  input wire [7:0] mode_select_threshold,
  input wire [7:0] mode_select_forced,
  // host data
  input wire host_valid,
  output wire host_ready,
  input wire [`TWS_BLK_W-1:0] host_data,
  output reg disconnect,
  // status to host
  output reg status_valid,
  input wire status_ready,
  output reg status_check,
  output reg [3:0] sense_key,
  output reg end_of_media_flag,
  // tape transport
  output wire tape_valid,
  input wire tape_ready,
  output wire [`TWS_BLK_W-1:0] tape_data,
  output wire tape_repeat,
  output wire tape_gap_req,
  output wire [7:0] tape_gap_inches,
  input wire tape_gap_done,
  input wire tape_verify_ok,
  input wire tape_verify_fail,
  input wire tape_early_warning,
  input wire tape_phys_end,
  input wire tape_hw_error,
  // read-side events
  input wire read_reposition,
  input wire read_halt,
  // counters
  output reg [7:0] data_error_count,
  output reg [7:0] data_underrun_count
);
  // host side states
  localparam H_IDLE = 4'b0001;
  localparam H_XFER = 4'b0010;
  localparam H_WAITV = 4'b0100;
  localparam H_STAT = 4'b1000;
  // tape side states
  localparam W_STOP = 4'b0001;
  localparam W_STREAM = 4'b0010;
  localparam W_FORCE = 4'b0100;
  localparam W_GAP = 4'b1000;

  reg [3:0] hstate;
  reg [3:0] wstate;
  reg [23:0] in_left;
  reg [23:0] pend;
  reg [`TWS_OCC_W-1:0] occ;
  reg [`TWS_AW-1:0] wptr;
  reg [`TWS_AW-1:0] rptr;
  reg [1:0] settle;
  reg [`TWS_BLK_W-1:0] sk0;
  reg [`TWS_BLK_W-1:0] sk1;
  reg [1:0] sk_cnt;
  reg [`TWS_BLK_W-1:0] last_blk;
  reg [`TWS_BLK_W-1:0] vfy_blk;
  reg redo;
  reg [4:0] retry;
  reg [3:0] thresh;
  reg [7:0] force_lim;
  reg force_ext;
  reg [7:0] force_cnt;
  reg ew_seen;
  reg err_flag;
  reg [3:0] err_key;
  reg err_eom;
  reg read_go;
  wire [`TWS_BLK_W-1:0] rd_data;

  // ==========================================================
  // command decode
  wire cmd_fire = cmd_valid & cmd_ready;
  wire [7:0] opcode = cmd_block[`TWS_OP_HI:`TWS_OP_LO];
  wire is_write = (opcode == `TWS_OP_WRITE);
  wire is_read = (opcode == `TWS_OP_READ);
  wire form_ok = cmd_block[`TWS_FIXED_BIT] &
    (cmd_block[`TWS_B5_HI:`TWS_B5_LO] == `TWS_ZERO8);
  wire [23:0] blk_count = cmd_block[`TWS_CNT_HI:`TWS_CNT_LO];
  wire pos_ok = prev_positions_write | beginning_of_media_flag;
  assign cmd_ready = (hstate == H_IDLE);
  assign read_start = read_go;

  // ==========================================================
  // two-entry buffer between host and block store
  wire sk_in = host_valid & host_ready;
  wire sk_out = (sk_cnt != 2'h0) & (occ != `TWS_OCC_FULL);
  assign host_ready = (hstate == H_XFER) & (in_left != `TWS_CNT24_ZERO) &
    (sk_cnt != 2'h2) & ~disconnect;

  // ==========================================================
  // tape side handshake
  wire data_ok = (settle == `TWS_SETTLE_DONE) & (occ != `TWS_OCC_ZERO);
  wire stream_go = (wstate == W_STREAM) & ~err_flag;
  // the beat count gates the repeat itself, so a limit of n sends exactly n copies
  wire force_go = (wstate == W_FORCE) & ~err_flag & (force_ext | (force_cnt != force_lim));
  assign tape_valid = (stream_go & (data_ok | redo)) | force_go;
  assign tape_repeat = force_go;
  assign tape_data = redo ? vfy_blk : (force_go ? last_blk : rd_data);
  assign tape_gap_req = (wstate == W_GAP);
  assign tape_gap_inches = `TWS_GAP_INCHES;
  wire beat = tape_valid & tape_ready;
  wire pop = beat & stream_go & ~redo;
  wire push = sk_out;
  wire underrun = (wstate == W_STREAM) & ~data_ok & ~redo & ~err_flag;

  // ==========================================================
  // block store
  tws_blkmem u_mem
  (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wptr),
    .wr_data(sk0),
    .rd_addr(rptr),
    .rd_data(rd_data)
  );

  // ==========================================================
  // skid registers; the head always sits in sk0
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sk0 <= {`TWS_BLK_W{1'b0}};
      sk1 <= {`TWS_BLK_W{1'b0}};
      sk_cnt <= 2'h0;
    end
    else if (err_flag & status_valid & status_ready)
    begin
      sk_cnt <= 2'h0;
    end
    else
    begin
      if (sk_out)
      begin
        sk0 <= sk1;
      end
      if (sk_in & ((sk_cnt == 2'h0) | ((sk_cnt == 2'h1) & sk_out)))
      begin
        sk0 <= host_data;
      end
      else if (sk_in)
      begin
        sk1 <= host_data;
      end
      sk_cnt <= sk_cnt + {1'b0, sk_in} - {1'b0, sk_out};
    end
  end

  // ==========================================================
  // occupancy and pointers; flushed once an error is reported
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      occ <= `TWS_OCC_ZERO;
      wptr <= {`TWS_AW{1'b0}};
      rptr <= {`TWS_AW{1'b0}};
      settle <= 2'h0;
    end
    else if (err_flag & status_valid & status_ready)
    begin
      occ <= `TWS_OCC_ZERO;
      wptr <= {`TWS_AW{1'b0}};
      rptr <= {`TWS_AW{1'b0}};
      settle <= 2'h0;
    end
    else
    begin
      occ <= occ + {3'h0, push} - {3'h0, pop};
      if (push)
      begin
        wptr <= (wptr == `TWS_PTR_LAST) ? {`TWS_AW{1'b0}} : wptr + `TWS_OCC_ONE;
      end
      if (pop)
      begin
        rptr <= (rptr == `TWS_PTR_LAST) ? {`TWS_AW{1'b0}} : rptr + `TWS_OCC_ONE;
      end
      // registered read needs two quiet cycles before the head is trusted
      if (pop | (occ == `TWS_OCC_ZERO))
      begin
        settle <= 2'h0;
      end
      else if (settle != `TWS_SETTLE_DONE)
      begin
        settle <= settle + 2'h1;
      end
    end
  end

  // ==========================================================
  // parameters: whichever command came last wins; set parameters wins when both strobe in one cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      thresh <= `TWS_THR_DEFAULT;
      force_lim <= `TWS_ZERO8;
      force_ext <= 1'b0;
    end
    else if (set_param_strobe)
    begin
      thresh <= (set_param_min_blocks == `TWS_ZERO8) ? `TWS_THR_DEFAULT :
        set_param_min_blocks[3:0];
      force_ext <= set_param_extended;
      if (set_param_extended)
      begin
        force_lim <= `TWS_FORCE_MAX;
      end
    end
    else if (mode_select_strobe)
    begin
      thresh <= (mode_select_threshold == `TWS_ZERO8) ? `TWS_THR_DEFAULT :
        mode_select_threshold[3:0];
      force_lim <= mode_select_forced;
      force_ext <= 1'b0;
    end
  end

  // ==========================================================
  // disconnect in nonbuffered mode: full drops, threshold reconnects
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      disconnect <= 1'b0;
    end
    else if (hstate != H_XFER)
    begin
      disconnect <= 1'b0;
    end
    else if (~buffered_mode & disconnect_allowed & (occ == `TWS_OCC_FULL))
    begin
      disconnect <= 1'b1;
    end
    else if (occ <= thresh)
    begin
      disconnect <= 1'b0;
    end
  end

  // ==========================================================
  // tape writer
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wstate <= W_STOP;
      force_cnt <= `TWS_ZERO8;
      last_blk <= {`TWS_BLK_W{1'b0}};
    end
    else
    begin
      if (pop)
      begin
        last_blk <= rd_data;
      end
      case (wstate)
        W_STOP:
        begin
          if (data_ok & ~err_flag)
          begin
            wstate <= W_STREAM;
          end
        end
        W_STREAM:
        begin
          force_cnt <= `TWS_ZERO8;
          if (err_flag)
          begin
            wstate <= W_STOP;
          end
          else if (underrun & (occ == `TWS_OCC_ZERO))
          begin
            if ((force_lim != `TWS_ZERO8) | force_ext)
            begin
              wstate <= W_FORCE;
            end
            else
            begin
              wstate <= qic24_mode ? W_GAP : W_STOP;
            end
          end
        end
        W_FORCE:
        begin
          if (beat)
          begin
            force_cnt <= force_cnt + `TWS_CNT8_ONE;
          end
          if (err_flag)
          begin
            wstate <= W_STOP;
          end
          else if (data_ok)
          begin
            wstate <= W_STREAM;
          end
          else if ((~force_ext & (force_cnt == force_lim)) | (force_ext & tape_phys_end))
          begin
            wstate <= qic24_mode ? W_GAP : W_STOP;
          end
        end
        W_GAP:
        begin
          if (tape_gap_done)
          begin
            wstate <= W_STOP;
          end
        end
        default:
        begin
          wstate <= W_STOP;
        end
      endcase
    end
  end

  // ==========================================================
  // verify tracking and rewrite of failed blocks
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend <= `TWS_CNT24_ZERO;
      vfy_blk <= {`TWS_BLK_W{1'b0}};
      redo <= 1'b0;
      retry <= 5'h00;
    end
    else if (err_flag)
    begin
      pend <= `TWS_CNT24_ZERO;
      redo <= 1'b0;
      retry <= 5'h00;
    end
    else
    begin
      if (pop)
      begin
        vfy_blk <= rd_data;
      end
      pend <= pend + {23'h0, pop} - {23'h0, tape_verify_ok & (pend != `TWS_CNT24_ZERO)};
      if (tape_verify_ok)
      begin
        retry <= 5'h00;
      end
      else if (tape_verify_fail)
      begin
        retry <= retry + 5'h01;
      end
      // a fail wins over the resend beat; an ok must not keep the resend alive
      if (tape_verify_fail)
      begin
        redo <= 1'b1;
      end
      else if (beat & redo)
      begin
        redo <= 1'b0;
      end
    end
  end

  // ==========================================================
  // error capture; a new error wins over the clear by reporting
  wire media_fail = tape_verify_fail & (retry == `TWS_RETRY_LAST);
  wire ew_hit = ew_seen & pop;
  wire new_err = media_fail | tape_hw_error | ew_hit |
    (tape_phys_end & (wstate != W_STOP));
  wire err_clr = err_flag & status_valid & status_ready & status_check;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      err_flag <= 1'b0;
      err_key <= `TWS_SK_GOOD;
      err_eom <= 1'b0;
      ew_seen <= 1'b0;
    end
    else
    begin
      if (tape_early_warning)
      begin
        ew_seen <= 1'b1;
      end
      else if (ew_hit)
      begin
        ew_seen <= 1'b0;
      end
      if (new_err & (~err_flag | err_clr))
      begin
        err_flag <= 1'b1;
        err_eom <= ew_hit | tape_phys_end;
        if (tape_hw_error)
        begin
          err_key <= `TWS_SK_HW;
        end
        else if (ew_hit & ~media_fail)
        begin
          err_key <= `TWS_SK_OVERFLOW;
        end
        else
        begin
          err_key <= `TWS_SK_MEDIA;
        end
      end
      else if (err_clr)
      begin
        err_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // host command sequencing and status
  wire recv_done = (in_left == `TWS_CNT24_ZERO) & (sk_cnt == 2'h0);
  wire tape_done = (occ == `TWS_OCC_ZERO) & (pend == `TWS_CNT24_ZERO) & ~redo;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hstate <= H_IDLE;
      in_left <= `TWS_CNT24_ZERO;
      status_valid <= 1'b0;
      status_check <= 1'b0;
      sense_key <= `TWS_SK_GOOD;
      end_of_media_flag <= 1'b0;
      read_go <= 1'b0;
    end
    else
    begin
      read_go <= 1'b0;
      case (hstate)
        H_IDLE:
        begin
          if (cmd_fire)
          begin
            hstate <= H_STAT;
            status_valid <= 1'b1;
            status_check <= 1'b1;
            sense_key <= `TWS_SK_ILLEGAL;
            end_of_media_flag <= 1'b0;
            if ((is_write | is_read) & err_flag)
            begin
              sense_key <= err_key;
              end_of_media_flag <= err_eom;
            end
            else if (is_read & ~prev_write_type & form_ok)
            begin
              status_check <= 1'b0;
              sense_key <= `TWS_SK_GOOD;
              read_go <= 1'b1;
            end
            else if (is_write & pos_ok & form_ok)
            begin
              hstate <= H_XFER;
              status_valid <= 1'b0;
              status_check <= 1'b0;
              sense_key <= `TWS_SK_GOOD;
              in_left <= blk_count;
            end
            // otherwise illegal request, which covers read after write
          end
        end
        H_XFER:
        begin
          if (sk_in)
          begin
            in_left <= in_left - `TWS_CNT24_ONE;
          end
          if (err_flag)
          begin
            hstate <= H_STAT;
            status_valid <= 1'b1;
            status_check <= 1'b1;
            sense_key <= err_key;
            end_of_media_flag <= err_eom;
          end
          else if (recv_done & buffered_mode)
          begin
            hstate <= H_STAT;
            status_valid <= 1'b1;
          end
          else if (recv_done)
          begin
            hstate <= H_WAITV;
          end
        end
        H_WAITV:
        begin
          if (err_flag)
          begin
            hstate <= H_STAT;
            status_valid <= 1'b1;
            status_check <= 1'b1;
            sense_key <= err_key;
            end_of_media_flag <= err_eom;
          end
          else if (tape_done)
          begin
            hstate <= H_STAT;
            status_valid <= 1'b1;
          end
        end
        H_STAT:
        begin
          if (status_ready)
          begin
            hstate <= H_IDLE;
            status_valid <= 1'b0;
          end
        end
        default:
        begin
          hstate <= H_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // event counters, wrapping at eight bits
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_error_count <= `TWS_ZERO8;
      data_underrun_count <= `TWS_ZERO8;
    end
    else
    begin
      if (read_reposition | tape_verify_fail)
      begin
        data_error_count <= data_error_count + `TWS_CNT8_ONE;
      end
      if (read_halt | (underrun & (occ == `TWS_OCC_ZERO)))
      begin
        data_underrun_count <= data_underrun_count + `TWS_CNT8_ONE;
      end
    end
  end
endmodule

// ---- inc/tws_defs.vh ----
// constants for the tape write command sequencer
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH
// ==========================================================
// command block layout
`define TWS_OP_WRITE 8'h0A
`define TWS_OP_READ 8'h08
`define TWS_FIXED_BIT 8
`define TWS_LUN_HI 15
`define TWS_LUN_LO 13
`define TWS_CNT_HI 39
`define TWS_CNT_LO 16
`define TWS_OP_HI 7
`define TWS_OP_LO 0
`define TWS_B5_HI 47
`define TWS_B5_LO 40
`define TWS_ZERO8 8'h00
// ==========================================================
// sense keys
`define TWS_SK_GOOD 4'h0
`define TWS_SK_MEDIA 4'h3
`define TWS_SK_HW 4'h4
`define TWS_SK_ILLEGAL 4'h5
`define TWS_SK_OVERFLOW 4'hD
// ==========================================================
// buffer and limits
`define TWS_BLK_W 16
`define TWS_DEPTH 15
`define TWS_AW 4
`define TWS_OCC_W 4
`define TWS_OCC_FULL 4'hF
`define TWS_OCC_ZERO 4'h0
`define TWS_OCC_ONE 4'h1
`define TWS_PTR_LAST 4'hE
`define TWS_THR_DEFAULT 4'h8
`define TWS_FORCE_MAX 8'hFF
`define TWS_RETRY_LAST 5'h0F
`define TWS_GAP_INCHES 8'h2D
`define TWS_CNT24_ZERO 24'h000000
`define TWS_CNT24_ONE 24'h000001
`define TWS_CNT8_ONE 8'h01
`define TWS_SETTLE_DONE 2'h2
`endif

// ---- tb/tws_props.sv ----
// checker for the write command sequencer ports
`timescale 1ns/1ps
module tws_props
(
  // clock and reset
  input wire clk,
  input wire reset_n,
  // host side
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [47:0] cmd_block,
  input wire prev_write_type,
  input wire prev_positions_write,
  input wire beginning_of_media_flag,
  input wire host_ready,
  input wire disconnect,
  input wire status_valid,
  input wire status_ready,
  input wire status_check,
  input wire [3:0] sense_key,
  // tape side and counters
  input wire tape_valid,
  input wire tape_gap_req,
  input wire [7:0] tape_gap_inches,
  input wire tape_verify_fail,
  input wire read_reposition,
  input wire read_halt,
  input wire [7:0] data_error_count,
  input wire [7:0] data_underrun_count
);
  // ==========
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // a taken command, and an idle moment with the host idle, no tape beat offered and no status pending
  wire take = cmd_valid && cmd_ready;
  wire quiet = cmd_ready && !tape_valid && !status_valid;
  a_bad_opcode: assert property (take && cmd_block[7:0] != 8'h0A && cmd_block[7:0] != 8'h08
    |=> status_valid && status_check && sense_key == 4'h5) else $error("bad opcode not refused");
  a_read_refused: assert property (take && cmd_block[7:0] == 8'h08 && prev_write_type
    |=> status_check && sense_key == 4'h5) else $error("read after write not refused");
  a_write_refused: assert property (take && cmd_block[7:0] == 8'h0A
    && !prev_positions_write && !beginning_of_media_flag |=> status_check && sense_key == 4'h5)
    else $error("misplaced write not refused");
  a_halt_count: assert property (quiet && read_halt
    |=> data_underrun_count == $past(data_underrun_count) + 8'h01) else $error("halt not counted");
  a_reread_count: assert property (quiet && read_reposition && !tape_verify_fail
    |=> data_error_count == $past(data_error_count) + 8'h01) else $error("reread not counted");
  a_gap_length: assert property (tape_gap_req |-> tape_gap_inches == 8'h2D)
    else $error("gap length wrong");
  a_disc_stall: assert property (disconnect |-> !host_ready)
    else $error("data taken while disconnected");
  a_status_hold: assert property (status_valid && !status_ready |=> status_valid && $stable(sense_key))
    else $error("status dropped early");
  // main scenarios reached
  c_disc: cover property (disconnect);
  c_gap: cover property (tape_gap_req);
  c_good: cover property (status_valid && !status_check);
endmodule
bind tws_sequencer tws_props tws_props_i (.*);

// ---- tb/tws_sequencer_tb.sv ----
// self-checking bench for the write command sequencer
`timescale 1ns/1ps
`include "tws_defs.vh"
module tws_sequencer_tb;
  // ==========
  reg clk = 1'h0, reset_n = 1'h0, stall = 1'h0;
  reg cmd_valid = 1'h0, host_valid = 1'h0, status_ready = 1'h0;
  reg prev_write_type = 1'h0, prev_positions_write = 1'h0, beginning_of_media_flag = 1'h0;
  reg buffered_mode = 1'h0, disconnect_allowed = 1'h0, qic24_mode = 1'h0;
  reg set_param_strobe = 1'h0, set_param_extended = 1'h0, mode_select_strobe = 1'h0;
  reg tape_verify_fail = 1'h0, tape_early_warning = 1'h0, tape_phys_end = 1'h0, tape_hw_error = 1'h0;
  reg read_reposition = 1'h0, read_halt = 1'h0;
  reg [7:0] set_param_min_blocks = 8'h00, mode_select_threshold = 8'h00, mode_select_forced = 8'h00;
  reg [47:0] cmd_block = 48'h0;
  reg [15:0] host_data = 16'h0000;
  wire cmd_ready, read_start, host_ready, disconnect, status_valid, status_check, end_of_media_flag;
  wire tape_valid, tape_ready, tape_repeat, tape_gap_req, tape_gap_done, tape_verify_ok;
  wire [3:0] sense_key;
  wire [15:0] tape_data, last;
  wire [7:0] tape_gap_inches, data_error_count, data_underrun_count, beats, reps, gaps;
  int fail_count = 0, checked = 0, n, got, b0;
  tws_sequencer tws_sequencer_i (.*);
  tws_tape_model tws_tape_model_i (.*);
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // ==========
  task results;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // a used-up wait bound ends the run
  task hang;
    if (n >= 2000)
    begin
      fail_count++;
      results();
    end
  endtask
  task cmd(input logic [47:0] b);
    cmd_valid <= 1'h1;
    cmd_block <= b;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!cmd_ready && n < 2000);
    cmd_valid <= 1'h0;
    hang();
  endtask
  task stat(input logic chk, input logic [3:0] key);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!status_valid && n < 2000);
    hang();
    status_ready <= 1'h1;
    check(status_check, chk);
    check(sense_key, key);
    @(posedge clk);
    status_ready <= 1'h0;
  endtask
  // offer words until cnt taken or lim idle cycles pass
  task put(input int cnt, input int lim);
    got = 0;
    n = 0;
    host_valid <= 1'h1;
    host_data <= b0[15:0];
    while (got < cnt && n < lim)
    begin
      @(posedge clk);
      n++;
      if (host_ready)
      begin
        got++;
        b0++;
        n = 0;
        host_data <= b0[15:0];
      end
    end
    host_valid <= 1'h0;
  endtask
  // ==========
  initial
  begin
    b0 = 256;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    set_param_strobe <= 1'h1;
    read_reposition <= 1'h1;
    read_halt <= 1'h1;
    @(posedge clk);
    set_param_strobe <= 1'h0;
    read_reposition <= 1'h0;
    read_halt <= 1'h0;
    repeat (3) @(posedge clk);
    check(data_error_count, 1);
    check(data_underrun_count, 1);
    cmd(48'h00000001010A);
    stat(1'h1, `TWS_SK_ILLEGAL);
    // tape at its start, so a bad opcode, the block layout or read after write refuses these
    beginning_of_media_flag <= 1'h1;
    cmd(48'h0000000101FF);
    stat(1'h1, `TWS_SK_ILLEGAL);
    cmd(48'h01000001010A);
    stat(1'h1, `TWS_SK_ILLEGAL);
    cmd(48'h00000001000A);
    stat(1'h1, `TWS_SK_ILLEGAL);
    prev_write_type <= 1'h1;
    cmd(48'h000000010108);
    stat(1'h1, `TWS_SK_ILLEGAL);
    prev_write_type <= 1'h0;
    cmd(48'h000000010108);
    @(posedge clk);
    check(read_start, 1);
    stat(1'h0, `TWS_SK_GOOD);
    // buffered: status before any block reaches the stalled tape
    beginning_of_media_flag <= 1'h1;
    buffered_mode <= 1'h1;
    stall <= 1'h1;
    cmd(48'h00000003010A);
    put(3, 200);
    stat(1'h0, `TWS_SK_GOOD);
    check(beats, 0);
    stall <= 1'h0;
    repeat (100) @(posedge clk);
    check(beats, 3);
    check(last, 16'h0102);
    // fill until refused, then refill as the tape drains
    beginning_of_media_flag <= 1'h0;
    prev_positions_write <= 1'h1;
    stall <= 1'h1;
    cmd(48'h00000014010A);
    put(20, 50);
    check(got, 17);
    stall <= 1'h0;
    @(posedge clk);
    put(3, 500);
    stat(1'h0, `TWS_SK_GOOD);
    repeat (200) @(posedge clk);
    check(beats, 23);
    // nonbuffered with disconnect
    buffered_mode <= 1'h0;
    disconnect_allowed <= 1'h1;
    stall <= 1'h1;
    cmd(48'h00000014010A);
    put(20, 50);
    check(disconnect, 1);
    stall <= 1'h0;
    @(posedge clk);
    put(20 - got, 500);
    stat(1'h0, `TWS_SK_GOOD);
    check(beats, 43);
    // forced streaming of two beats, then a blank gap
    mode_select_forced <= 8'h02;
    mode_select_strobe <= 1'h1;
    qic24_mode <= 1'h1;
    @(posedge clk);
    mode_select_strobe <= 1'h0;
    cmd(48'h00000001010A);
    put(1, 200);
    stat(1'h0, `TWS_SK_GOOD);
    repeat (30) @(posedge clk);
    check(reps, 2);
    check(gaps, 1);
    check(last, b0 - 1);
    // a block arriving mid-repeat resumes the stream with no gap
    mode_select_forced <= 8'h10;
    mode_select_strobe <= 1'h1;
    @(posedge clk);
    mode_select_strobe <= 1'h0;
    cmd(48'h00000002010A);
    put(1, 200);
    repeat (12) @(posedge clk);
    check(tape_repeat, 1);
    put(1, 200);
    stat(1'h0, `TWS_SK_GOOD);
    repeat (60) @(posedge clk);
    check(beats, 46);
    check(gaps, 2);
    // early warning behind a buffered write is reported on the next write
    buffered_mode <= 1'h1;
    stall <= 1'h1;
    tape_early_warning <= 1'h1;
    @(posedge clk);
    tape_early_warning <= 1'h0;
    cmd(48'h00000001010A);
    put(1, 200);
    stat(1'h0, `TWS_SK_GOOD);
    stall <= 1'h0;
    repeat (10) @(posedge clk);
    check(beats, 47);
    cmd(48'h00000001010A);
    stat(1'h1, `TWS_SK_OVERFLOW);
    check(end_of_media_flag, 1);
    results();
  end
endmodule

// ---- tb/tws_tape_model.sv ----
// tape transport model facing the sequencer
`timescale 1ns/1ps
module tws_tape_model
(
  // control
  input wire clk,
  input wire reset_n,
  input wire stall,
  // transport side
  input wire tape_valid,
  output wire tape_ready,
  input wire [15:0] tape_data,
  input wire tape_repeat,
  input wire tape_gap_req,
  output reg tape_verify_ok,
  output reg tape_gap_done,
  // observation
  output reg [7:0] beats,
  output reg [7:0] reps,
  output reg [7:0] gaps,
  output reg [15:0] last
);
  // ==========
  // a stalled transport forces the buffer to absorb the host
  assign tape_ready = !stall;
  // verify comes one clock after each beat, like a trailing read head
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tape_verify_ok <= 1'h0;
      tape_gap_done <= 1'h0;
      beats <= 8'h00;
      reps <= 8'h00;
      gaps <= 8'h00;
      last <= 16'h0000;
    end
    else
    begin
      tape_verify_ok <= tape_valid && tape_ready;
      tape_gap_done <= tape_gap_req && !tape_gap_done;
      if (tape_gap_req && !tape_gap_done)
        gaps <= gaps + 8'h01;
      if (tape_valid && tape_ready)
      begin
        last <= tape_data;
        if (tape_repeat)
          reps <= reps + 8'h01;
        else
          beats <= beats + 8'h01;
      end
    end
  end
endmodule
